// ### design/cascadable_reload_timer.sv
// Notes on behaviour
// - stop-on-receive halts timer after four bits
// - trimming modes ignore stop-on-receive
// - mode 00 never autostarts, 01 at transmit end
// - modes 10/11 trim, edge start/stop
// - auto-restart reloads at zero and continues, except mode 10
// - without auto-restart count to zero, stop; mode 10 holds at zero, running
// - each underflow sets second timer flag
// - clock codes 00 carrier, 01 subcarrier
// - codes 10/11 count sibling underflows
// - start loads reload high and low bytes
// - reload writes wait for next start or auto-restart reload
// - live count readable as two bytes
// - second timer control byte field layout
// - third timer control byte, same layout
// - third timer cascades first, second timer
// - third timer underflow sets its flag
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
`include "crt_regs.svh"
module cascadable_reload_timer (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic CLK_EN_IN,
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic CARRIER_CLK_IN,
  input wire logic SUBCARRIER_CLK_IN,
  input wire logic TX_END_IN,
  input wire logic RX_FOUR_BITS_IN,
  input wire logic TRIM_EDGE_IN,
  input wire logic TIMER_A_UNDERFLOW_IN,
  output logic TIMER_B_UNDERFLOW_OUT,
  output logic TIMER_C_UNDERFLOW_OUT,
  output logic TIMER_B_UNDERFLOW_FLAG_OUT,
  output logic TIMER_C_UNDERFLOW_FLAG_OUT
);
  // ***********************************************
  // pin synchronisers and timer instances
  // ***********************************************
  logic [4:0] pin_rise;
  crt_timer_if #(.W(16)) tb_if();
  crt_timer_if #(.W(16)) tc_if();

  // all pins except timer a underflow share one synchroniser bank
  crt_pin_sync #(.W(5)) u_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(NRST_IN),
    .ce_in(CLK_EN_IN),
    .pin_in({TRIM_EDGE_IN, RX_FOUR_BITS_IN, TX_END_IN, SUBCARRIER_CLK_IN, CARRIER_CLK_IN}),
    .rise_out(pin_rise)
  );

  crt_down_counter #(.W(16)) u_timer_b (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(NRST_IN),
    .ce_in(CLK_EN_IN),
    .tif(tb_if)
  );

  crt_down_counter #(.W(16)) u_timer_c (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(NRST_IN),
    .ce_in(CLK_EN_IN),
    .tif(tc_if)
  );

  // ***********************************************
  // register state
  // ***********************************************
  logic [7:0] b_ctrl_reg;
  logic [7:0] b_ctrl_next;
  logic [15:0] b_reload_reg;
  logic [15:0] b_reload_next;
  logic [7:0] c_ctrl_reg;
  logic [7:0] c_ctrl_next;
  logic [15:0] c_reload_reg;
  logic [15:0] c_reload_next;
  logic [3:0] cmd_reg;
  logic [3:0] cmd_next;
  logic b_flag_reg;
  logic b_flag_next;
  logic c_flag_reg;
  logic c_flag_next;
  logic awready_reg;
  logic awready_next;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic [1:0] bresp_next;
  logic arready_reg;
  logic arready_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [1:0] rresp_reg;
  logic [1:0] rresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_en;
  logic wr_hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic rd_hit;

  // ***********************************************
  // timer wiring
  // ***********************************************
  // timer b: code 10 counts timer a, code 11 counts timer c
  assign tb_if.ctrl = crt_pkg::crt_ctrl_t'(b_ctrl_reg);
  assign tb_if.reload_value = b_reload_reg;
  assign tb_if.sw_start = cmd_reg[0];
  assign tb_if.sw_stop = cmd_reg[1];
  assign tb_if.carrier_tick = pin_rise[0];
  assign tb_if.subcarrier_tick = pin_rise[1];
  assign tb_if.tx_end = pin_rise[2];
  assign tb_if.rx_four_bits = pin_rise[3];
  assign tb_if.trim_edge = pin_rise[4];
  assign tb_if.sib_low_uf = TIMER_A_UNDERFLOW_IN;
  assign tb_if.sib_high_uf = tc_if.underflow;
  // timer c: code 10 counts timer a, code 11 counts timer b
  assign tc_if.ctrl = crt_pkg::crt_ctrl_t'(c_ctrl_reg);
  assign tc_if.reload_value = c_reload_reg;
  assign tc_if.sw_start = cmd_reg[2];
  assign tc_if.sw_stop = cmd_reg[3];
  assign tc_if.carrier_tick = pin_rise[0];
  assign tc_if.subcarrier_tick = pin_rise[1];
  assign tc_if.tx_end = pin_rise[2];
  assign tc_if.rx_four_bits = pin_rise[3];
  assign tc_if.trim_edge = pin_rise[4];
  assign tc_if.sib_low_uf = TIMER_A_UNDERFLOW_IN;
  assign tc_if.sib_high_uf = tb_if.underflow;

  // ***********************************************
  // bus handshakes
  // ***********************************************
  // address and data are taken together, so no skid storage is needed
  always_comb begin
    wr_idx = S_AXI_AWADDR_IN[7:2];
    rd_idx = S_AXI_ARADDR_IN[7:2];
    wr_en = awready_reg & S_AXI_WSTRB_IN[0];
    wbyte = S_AXI_WDATA_IN[7:0];
    awready_next = S_AXI_AWVALID_IN & S_AXI_WVALID_IN & ~awready_reg & ~bvalid_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (awready_reg) begin
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_next = 1'b0;
    end
    arready_next = S_AXI_ARVALID_IN & ~arready_reg & ~rvalid_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = rd_hit ? `CRT_RESP_OKAY : `CRT_RESP_SLVERR;
      rdata_next = {24'h000000, rbyte};
    end else if (S_AXI_RREADY_IN) begin
      rvalid_next = 1'b0;
    end
  end

  // ***********************************************
  // decode and register writes
  // ***********************************************
  // reload writes never touch a running count
  always_comb begin
    b_ctrl_next = b_ctrl_reg;
    b_reload_next = b_reload_reg;
    c_ctrl_next = c_ctrl_reg;
    c_reload_next = c_reload_reg;
    cmd_next = 4'h0;
    wr_hit = 1'b1;
    case (wr_idx)
      `CRT_IDX_B_CTRL: if (wr_en) b_ctrl_next = wbyte & `CRT_CTRL_MASK;
      `CRT_IDX_B_RLD_HI: if (wr_en) b_reload_next[15:8] = wbyte;
      `CRT_IDX_B_RLD_LO: if (wr_en) b_reload_next[7:0] = wbyte;
      `CRT_IDX_C_CTRL: if (wr_en) c_ctrl_next = wbyte & `CRT_CTRL_MASK;
      `CRT_IDX_C_RLD_HI: if (wr_en) c_reload_next[15:8] = wbyte;
      `CRT_IDX_C_RLD_LO: if (wr_en) c_reload_next[7:0] = wbyte;
      `CRT_IDX_STATUS: if (wr_en) cmd_next = wbyte[`CRT_ST_C_STOP:`CRT_ST_B_START];
      `CRT_IDX_B_CNT_HI, `CRT_IDX_B_CNT_LO, `CRT_IDX_C_CNT_HI, `CRT_IDX_C_CNT_LO: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    // a new underflow beats a clear in the same cycle
    b_flag_next = tb_if.underflow
                | (b_flag_reg & ~(wr_en & (wr_idx == `CRT_IDX_STATUS) & wbyte[`CRT_ST_B_FLAG]));
    c_flag_next = tc_if.underflow
                | (c_flag_reg & ~(wr_en & (wr_idx == `CRT_IDX_STATUS) & wbyte[`CRT_ST_C_FLAG]));
  end

  // ***********************************************
  // read mux
  // ***********************************************
  // count bytes are live, so a two-byte read may straddle a decrement
  always_comb begin
    rbyte = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      `CRT_IDX_B_CTRL: rbyte = b_ctrl_reg;
      `CRT_IDX_B_RLD_HI: rbyte = b_reload_reg[15:8];
      `CRT_IDX_B_RLD_LO: rbyte = b_reload_reg[7:0];
      `CRT_IDX_B_CNT_HI: rbyte = tb_if.count[15:8];
      `CRT_IDX_B_CNT_LO: rbyte = tb_if.count[7:0];
      `CRT_IDX_C_CTRL: rbyte = c_ctrl_reg;
      `CRT_IDX_C_RLD_HI: rbyte = c_reload_reg[15:8];
      `CRT_IDX_C_RLD_LO: rbyte = c_reload_reg[7:0];
      `CRT_IDX_C_CNT_HI: rbyte = tc_if.count[15:8];
      `CRT_IDX_C_CNT_LO: rbyte = tc_if.count[7:0];
      `CRT_IDX_STATUS: rbyte = {4'h0, tc_if.running, tb_if.running, c_flag_reg, b_flag_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // ***********************************************
  // state registers
  // ***********************************************
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      b_ctrl_reg <= `CRT_CTRL_RST;
      b_reload_reg <= `CRT_RELOAD_RST;
      c_ctrl_reg <= `CRT_CTRL_RST;
      c_reload_reg <= `CRT_RELOAD_RST;
      cmd_reg <= 4'h0;
      b_flag_reg <= 1'b0;
      c_flag_reg <= 1'b0;
      awready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `CRT_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `CRT_RESP_OKAY;
      rdata_reg <= 32'h00000000;
    end else if (CLK_EN_IN) begin
      b_ctrl_reg <= b_ctrl_next;
      b_reload_reg <= b_reload_next;
      c_ctrl_reg <= c_ctrl_next;
      c_reload_reg <= c_reload_next;
      cmd_reg <= cmd_next;
      b_flag_reg <= b_flag_next;
      c_flag_reg <= c_flag_next;
      awready_reg <= awready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign S_AXI_AWREADY_OUT = awready_reg;
  assign S_AXI_WREADY_OUT = awready_reg;
  assign S_AXI_BVALID_OUT = bvalid_reg;
  assign S_AXI_BRESP_OUT = bresp_reg;
  assign S_AXI_ARREADY_OUT = arready_reg;
  assign S_AXI_RVALID_OUT = rvalid_reg;
  assign S_AXI_RRESP_OUT = rresp_reg;
  assign S_AXI_RDATA_OUT = rdata_reg;
  assign TIMER_B_UNDERFLOW_OUT = tb_if.underflow;
  assign TIMER_C_UNDERFLOW_OUT = tc_if.underflow;
  assign TIMER_B_UNDERFLOW_FLAG_OUT = b_flag_reg;
  assign TIMER_C_UNDERFLOW_FLAG_OUT = c_flag_reg;
endmodule

// ### design/crt_down_counter.sv
`timescale 1ns/10ps
// ***********************************************
// reloadable down counter, one per timer
// ***********************************************
module crt_down_counter #(parameter int W = 16) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  crt_timer_if.tmr tif
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic running_reg;
  logic running_next;
  logic uf_reg;
  logic uf_next;
  logic tick;
  logic trim_mode;
  logic start_ev;
  logic stop_ev;

  // start wins over stop, stop over counting
  always_comb begin
    case (tif.ctrl.clock_select)
      crt_pkg::CRT_CLK_CARRIER: tick = tif.carrier_tick;
      crt_pkg::CRT_CLK_SUBCARRIER: tick = tif.subcarrier_tick;
      crt_pkg::CRT_CLK_SIB_LOW: tick = tif.sib_low_uf;
      crt_pkg::CRT_CLK_SIB_HIGH: tick = tif.sib_high_uf;
      default: tick = 1'b0;
    endcase
    trim_mode = tif.ctrl.start_mode[1];
    start_ev = tif.sw_start
             | ((tif.ctrl.start_mode == crt_pkg::CRT_START_TX_END) & tif.tx_end)
             | (trim_mode & tif.trim_edge & ~running_reg);
    // receive stop is ignored while trimming
    stop_ev = tif.sw_stop
            | (trim_mode & tif.trim_edge & running_reg)
            | (~trim_mode & tif.ctrl.stop_on_receive & tif.rx_four_bits);
    count_next = count_reg;
    running_next = running_reg;
    uf_next = 1'b0;
    if (start_ev) begin
      count_next = tif.reload_value;
      running_next = 1'b1;
    end else if (stop_ev) begin
      running_next = 1'b0;
    end else if (running_reg && tick) begin
      if (count_reg != '0) begin
        count_next = count_reg - 1'b1;
      end else if (tif.ctrl.start_mode != crt_pkg::CRT_START_TRIM_NO_UF) begin
        uf_next = 1'b1;
        if (tif.ctrl.auto_restart) begin
          count_next = tif.reload_value;
        end else begin
          running_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
      running_reg <= 1'b0;
      uf_reg <= 1'b0;
    end else if (ce_in) begin
      count_reg <= count_next;
      running_reg <= running_next;
      uf_reg <= uf_next;
    end
  end

  assign tif.count = count_reg;
  assign tif.running = running_reg;
  assign tif.underflow = uf_reg;
endmodule

// ### design/crt_pin_sync.sv
`timescale 1ns/10ps
// ***********************************************
// two-stage synchroniser with rising-edge pulse
// ***********************************************
module crt_pin_sync #(parameter int W = 5) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] rise_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;
  logic [W-1:0] rise_reg;
  logic [W-1:0] rise_next;

  // edge seen only past the second stage
  always_comb begin
    rise_next = sync_reg & ~prev_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      rise_reg <= '0;
    end else if (ce_in) begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      rise_reg <= rise_next;
    end
  end

  assign rise_out = rise_reg;
endmodule

// ### design/crt_pkg.sv
package crt_pkg;

  typedef enum logic [1:0] {
    CRT_START_NONE = 2'h0,
    CRT_START_TX_END = 2'h1,
    CRT_START_TRIM_NO_UF = 2'h2,
    CRT_START_TRIM_UF = 2'h3
  } crt_start_mode_t;

  typedef enum logic [1:0] {
    CRT_CLK_CARRIER = 2'h0,
    CRT_CLK_SUBCARRIER = 2'h1,
    CRT_CLK_SIB_LOW = 2'h2,
    CRT_CLK_SIB_HIGH = 2'h3
  } crt_clk_sel_t;

  // control byte layout, bits 6 and 2 reserved
  typedef struct packed {
    logic stop_on_receive;
    logic rsvd6;
    crt_start_mode_t start_mode;
    logic auto_restart;
    logic rsvd2;
    crt_clk_sel_t clock_select;
  } crt_ctrl_t;

endpackage

// ### design/crt_regs.svh
`ifndef CRT_REGS_SVH
`define CRT_REGS_SVH

// ***********************************************
// register indexes, byte address is index * 4
// ***********************************************
`define CRT_IDX_B_CTRL 6'h14
`define CRT_IDX_B_RLD_HI 6'h15
`define CRT_IDX_B_RLD_LO 6'h16
`define CRT_IDX_B_CNT_HI 6'h17
`define CRT_IDX_B_CNT_LO 6'h18
`define CRT_IDX_C_CTRL 6'h19
`define CRT_IDX_C_RLD_HI 6'h1A
`define CRT_IDX_C_RLD_LO 6'h1B
`define CRT_IDX_C_CNT_HI 6'h1C
`define CRT_IDX_C_CNT_LO 6'h1D
`define CRT_IDX_STATUS 6'h1E

// ***********************************************
// field positions and reset values
// ***********************************************
`define CRT_CTRL_MASK 8'hBB
`define CRT_CTRL_RST 8'h00
`define CRT_RELOAD_RST 16'h0000
`define CRT_ST_B_FLAG 0
`define CRT_ST_C_FLAG 1
`define CRT_ST_B_RUN 2
`define CRT_ST_C_RUN 3
`define CRT_ST_B_START 4
`define CRT_ST_B_STOP 5
`define CRT_ST_C_START 6
`define CRT_ST_C_STOP 7

// ***********************************************
// bus answers
// ***********************************************
`define CRT_RESP_OKAY 2'h0
`define CRT_RESP_SLVERR 2'h2

`endif

// ### design/crt_timer_if.sv
`timescale 1ns/10ps
interface crt_timer_if #(parameter int W = 16);
  crt_pkg::crt_ctrl_t ctrl;
  logic [W-1:0] reload_value;
  logic sw_start;
  logic sw_stop;
  logic carrier_tick;
  logic subcarrier_tick;
  logic sib_low_uf;
  logic sib_high_uf;
  logic tx_end;
  logic rx_four_bits;
  logic trim_edge;
  logic [W-1:0] count;
  logic running;
  logic underflow;

  modport ctl(output ctrl, reload_value, sw_start, sw_stop, carrier_tick, subcarrier_tick,
              sib_low_uf, sib_high_uf, tx_end, rx_four_bits, trim_edge,
              input count, running, underflow);
  modport tmr(input ctrl, reload_value, sw_start, sw_stop, carrier_tick, subcarrier_tick,
              sib_low_uf, sib_high_uf, tx_end, rx_four_bits, trim_edge,
              output count, running, underflow);
endinterface

// ### verification/crt_checker_sva.sv
`timescale 1ns/10ps
// ***********************************
// bus handshake and underflow checks
// ***********************************
module crt_checker (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic S_AXI_AWVALID_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WVALID_IN,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic [31:0] S_AXI_RDATA_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic TIMER_B_UNDERFLOW_OUT,
  input wire logic TIMER_C_UNDERFLOW_OUT,
  input wire logic TIMER_B_UNDERFLOW_FLAG_OUT,
  input wire logic TIMER_C_UNDERFLOW_FLAG_OUT
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!NRST_IN);

  // register bytes only reachable through a full write handshake
  a_wr_accept: assert property (S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT
    |=> S_AXI_AWREADY_OUT && S_AXI_WREADY_OUT ##1 S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT)
    else $error("write not accepted in two cycles");
  a_bvalid_drop: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
    else $error("write response not retired");
  a_rd_accept: assert property (S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT
    |=> S_AXI_ARREADY_OUT ##1 S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
    else $error("read not answered in two cycles");
  a_rvalid_drop: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
    else $error("read data not retired");
  a_rdata_byte: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  a_flag_b_set: assert property (TIMER_B_UNDERFLOW_OUT |=> TIMER_B_UNDERFLOW_FLAG_OUT)
    else $error("underflow did not set flag b");
  a_flag_c_set: assert property (TIMER_C_UNDERFLOW_OUT |=> TIMER_C_UNDERFLOW_FLAG_OUT)
    else $error("underflow did not set flag c");
  a_flag_b_cause: assert property ($rose(TIMER_B_UNDERFLOW_FLAG_OUT) |-> $past(TIMER_B_UNDERFLOW_OUT))
    else $error("flag b rose without underflow");
  // synchronised pin ticks are at least two cycles apart; the timer a underflow input is raw, so this holds only while it pulses
  a_uf_b_single: assert property (TIMER_B_UNDERFLOW_OUT |=> !TIMER_B_UNDERFLOW_OUT)
    else $error("underflow b longer than one cycle");

  c_uf_b: cover property (TIMER_B_UNDERFLOW_OUT);
  c_uf_c: cover property (TIMER_C_UNDERFLOW_OUT);
  c_wr: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
endmodule

bind cascadable_reload_timer crt_checker chk_u (.CLK_SYS_IN, .NRST_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT,
  .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT,
  .S_AXI_RDATA_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .TIMER_B_UNDERFLOW_OUT, .TIMER_C_UNDERFLOW_OUT,
  .TIMER_B_UNDERFLOW_FLAG_OUT, .TIMER_C_UNDERFLOW_FLAG_OUT);

// ### verification/testbench.sv
`timescale 1ns/10ps
`include "crt_regs.svh"
module testbench;
  logic clk_sys;
  logic nrst;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rd_val;
  logic [1:0] bresp, rresp;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic uf_b, uf_c, flag_b, flag_c;
  // pins: carrier, subcarrier, tx end, four bits, trim edge, sibling a underflow
  logic [5:0] pins;
  int mismatches;
  int n_compared;
  int i;

  // clock enable tied high: freezing is not exercised here
  cascadable_reload_timer dut_u (.CLK_SYS_IN(clk_sys), .NRST_IN(nrst), .CLK_EN_IN(1'b1),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .CARRIER_CLK_IN(pins[0]), .SUBCARRIER_CLK_IN(pins[1]), .TX_END_IN(pins[2]), .RX_FOUR_BITS_IN(pins[3]),
    .TRIM_EDGE_IN(pins[4]), .TIMER_A_UNDERFLOW_IN(pins[5]), .TIMER_B_UNDERFLOW_OUT(uf_b),
    .TIMER_C_UNDERFLOW_OUT(uf_c), .TIMER_B_UNDERFLOW_FLAG_OUT(flag_b), .TIMER_C_UNDERFLOW_FLAG_OUT(flag_c));

  // ***********************************
  // bus tasks and comparison
  // ***********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // waits end only through the watchdog, so a lost answer cannot pass silently
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er = `CRT_RESP_OKAY);
    @(posedge clk_sys);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk_sys); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    check({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er = `CRT_RESP_OKAY);
    @(posedge clk_sys);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rd_val = rdata;
    check({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    check(rd_val, exp);
    rready <= 1'b0;
  endtask

  // one pin pulse, then room for the three-edge synchroniser
  task automatic pulse(input int k);
    @(posedge clk_sys);
    pins[k] <= 1'b1;
    @(posedge clk_sys);
    pins[k] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ***********************************
  // clock, watchdog and test sequence
  // ***********************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // whole sequence needs under two thousand cycles
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end

  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, pins} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    for (i = 'h14; i <= 'h1E; i++) rd(i[5:0], 32'h0);
    wr(`CRT_IDX_B_CTRL, 8'hFF);
    rd(`CRT_IDX_B_CTRL, 32'hBB);
    wr(`CRT_IDX_C_CTRL, 8'hFF);
    rd(`CRT_IDX_C_CTRL, 32'hBB);
    wr(`CRT_IDX_C_CTRL, 8'h00);
    wr(6'h20, 8'h55, `CRT_RESP_SLVERR);
    rd(6'h20, 32'h0, `CRT_RESP_SLVERR);
    wr(`CRT_IDX_B_CNT_LO, 8'h77);
    rd(`CRT_IDX_B_CNT_LO, 32'h0);
    // start loads reload, later reload writes wait for next start
    wr(`CRT_IDX_B_RLD_HI, 8'h01);
    wr(`CRT_IDX_B_RLD_LO, 8'h02);
    wr(`CRT_IDX_B_CTRL, 8'h00);
    wr(`CRT_IDX_STATUS, 8'h10);
    rd(`CRT_IDX_B_CNT_HI, 32'h01);
    rd(`CRT_IDX_B_CNT_LO, 32'h02);
    wr(`CRT_IDX_B_RLD_LO, 8'h05);
    rd(`CRT_IDX_B_CNT_LO, 32'h02);
    pulse(0);
    rd(`CRT_IDX_B_CNT_LO, 32'h01);
    rd(`CRT_IDX_B_CNT_HI, 32'h01);
    // auto restart then one-shot
    wr(`CRT_IDX_STATUS, 8'h20);
    wr(`CRT_IDX_B_RLD_HI, 8'h00);
    wr(`CRT_IDX_B_RLD_LO, 8'h02);
    wr(`CRT_IDX_B_CTRL, 8'h08);
    wr(`CRT_IDX_STATUS, 8'h10);
    repeat (3) pulse(0);
    rd(`CRT_IDX_B_CNT_LO, 32'h02);
    rd(`CRT_IDX_STATUS, 32'h05);
    check({31'h0, flag_b}, 32'h1);
    wr(`CRT_IDX_STATUS, 8'h01);
    rd(`CRT_IDX_STATUS, 32'h04);
    wr(`CRT_IDX_B_CTRL, 8'h00);
    repeat (3) pulse(0);
    rd(`CRT_IDX_STATUS, 32'h01);
    rd(`CRT_IDX_B_CNT_LO, 32'h00);
    // clock codes 01, 10, 11; timer c underflows on every carrier tick
    wr(`CRT_IDX_C_CTRL, 8'h08);
    wr(`CRT_IDX_STATUS, 8'h41);
    for (i = 1; i < 4; i++) begin
      wr(`CRT_IDX_B_CTRL, i[7:0]);
      wr(`CRT_IDX_STATUS, 8'h10);
      pulse((i == 2) ? 5 : (i == 1) ? 1 : 0);
      rd(`CRT_IDX_B_CNT_LO, 32'h01);
    end
    check({31'h0, flag_c}, 32'h1);
    wr(`CRT_IDX_STATUS, 8'hA3);
    rd(`CRT_IDX_STATUS, 32'h00);
    // third timer counting sibling underflows
    wr(`CRT_IDX_C_RLD_LO, 8'h02);
    wr(`CRT_IDX_C_CTRL, 8'h03);
    wr(`CRT_IDX_B_RLD_LO, 8'h00);
    wr(`CRT_IDX_B_CTRL, 8'h08);
    wr(`CRT_IDX_STATUS, 8'h50);
    pulse(0);
    rd(`CRT_IDX_C_CNT_LO, 32'h01);
    wr(`CRT_IDX_C_CTRL, 8'h02);
    wr(`CRT_IDX_STATUS, 8'h40);
    pulse(5);
    rd(`CRT_IDX_C_CNT_LO, 32'h01);
    wr(`CRT_IDX_STATUS, 8'hA3);
    // automatic start, stop on receive, trimming
    wr(`CRT_IDX_B_RLD_LO, 8'h02);
    wr(`CRT_IDX_B_CTRL, 8'h00);
    pulse(2);
    rd(`CRT_IDX_STATUS, 32'h00);
    wr(`CRT_IDX_B_CTRL, 8'h10);
    pulse(2);
    rd(`CRT_IDX_STATUS, 32'h04);
    rd(`CRT_IDX_B_CNT_LO, 32'h02);
    wr(`CRT_IDX_B_CTRL, 8'h90);
    pulse(3);
    rd(`CRT_IDX_STATUS, 32'h00);
    wr(`CRT_IDX_B_CTRL, 8'h10);
    pulse(2);
    pulse(3);
    rd(`CRT_IDX_STATUS, 32'h04);
    wr(`CRT_IDX_STATUS, 8'h20);
    wr(`CRT_IDX_B_CTRL, 8'hB0);
    pulse(4);
    rd(`CRT_IDX_STATUS, 32'h04);
    pulse(3);
    rd(`CRT_IDX_STATUS, 32'h04);
    pulse(4);
    rd(`CRT_IDX_STATUS, 32'h00);
    wr(`CRT_IDX_B_RLD_LO, 8'h01);
    wr(`CRT_IDX_B_CTRL, 8'hA0);
    pulse(4);
    repeat (3) pulse(0);
    rd(`CRT_IDX_STATUS, 32'h04);
    rd(`CRT_IDX_B_CNT_LO, 32'h00);
    wr(`CRT_IDX_B_CTRL, 8'hB0);
    pulse(0);
    rd(`CRT_IDX_STATUS, 32'h01);
    report_and_stop;
  end
endmodule
